/* rtl/rst_comb_consts.svh */
/*
 * Offsets, field positions, reset values and timing counts of the reset
 * source combiner. Assumes inclusion by bare name from rtl/.
 */
`ifndef RST_COMB_CONSTS_SVH
`define RST_COMB_CONSTS_SVH

// ************************************************************
// Register map (byte addresses)
// ************************************************************
`define ADDR_W              8
`define OFF_CAUSE           8'h00
`define OFF_SWTRIG          8'h10
`define ALIAS_CLR           2'h1
`define ALIAS_SET           2'h2
`define ALIAS_INV           2'h3

// ************************************************************
// Cause status fields
// ************************************************************
`define CAUSE_W             10
`define BIT_POR             0
`define BIT_BOR             1
`define BIT_IDLE            2
`define BIT_SLEEP           3
`define BIT_WDT             4
`define BIT_SOFT            6
`define BIT_PIN             7
`define BIT_VREG            8
`define BIT_MISMATCH        9
`define CAUSE_IMPL_MASK     10'h3df
`define CAUSE_POR_VALUE     10'h003
`define BIT_TRIG            0

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS       5
`define FETCH_DELAY_CYC     8
`define FETCH_CNT_W         4

`endif

/* rtl/rst_comb_pkg.sv */
/*
 * Types shared by the reset source combiner.
 * Assumes the constants header is compiled alongside.
 */
package rst_comb_pkg;
  typedef enum logic [1:0] {
    TRIG_IDLE  = 2'b00,
    TRIG_ARMED = 2'b01,
    TRIG_FIRE  = 2'b11
  } trig_state_e;

  typedef enum logic [1:0] {
    ALIAS_NONE_OP = 2'h0,
    ALIAS_CLR_OP  = 2'h1,
    ALIAS_SET_OP  = 2'h2,
    ALIAS_INV_OP  = 2'h3
  } alias_op_e;
endpackage

/* rtl/sync_2ff.sv */
/*
 * Two flip-flop level synchroniser, one per bit.
 * Assumes inputs are asynchronous levels held for at least two clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* rtl/fetch_delay.sv */
/*
 * Holds the fetch enable low for a fixed count after system reset falls.
 * Assumes sys_rst is synchronous to core_clk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rst_comb_consts.svh"
module fetch_delay (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Reset in, fetch permission out
  input  wire logic sys_rst,
  output logic      fetch_en
);
  logic [`FETCH_CNT_W-1:0] cnt_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n || sys_rst) begin
      cnt_q    <= '0;
      fetch_en <= 1'b0;
    end else if (cnt_q != `FETCH_CNT_W'(`FETCH_DELAY_CYC)) begin
      cnt_q    <= cnt_q + `FETCH_CNT_W'(1);
      fetch_en <= 1'b0;
    end else begin
      fetch_en <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* rtl/reset_source_combiner.sv */
/*
 * Reset source combiner: merges reset requests into one system reset,
 * records the cause, and offers a software reset trigger.
 * Assumes detectors hold their requests as levels, that power-on reset
 * arrives as a synchronous pulse, and that the bus master follows the
 * one-cycle strobe protocol.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rst_comb_consts.svh"

// Operation
// [RULE1] Any active source asserts system reset
// [RULE2] Each reset sets its cause flag
// [RULE3] Power-on clears status, sets low two bits
// [RULE4] Software may set or clear status bits
// [RULE5] Software-set flags never cause reset
// [RULE6] Trigger register holds one trigger bit
// [RULE7] Clear alias at offset plus four
// [RULE8] Set alias at offset plus eight
// [RULE9] Invert alias at offset plus twelve
// [RULE10] Software ignores alias read data
// [RULE11] Unimplemented bits read zero, ignore writes
// [RULE12] Fixed status bit positions
// [RULE13] Soft reset fires on read after write
// [RULE14] Eight clocks before fetch after release
// [RULE15] Async requests synchronised before use
// [RULE16] Hardware set beats software clear
module reset_source_combiner
  import rst_comb_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Reset sources
  input  wire logic                por_pulse,
  input  wire logic                brownout_req,
  input  wire logic                external_pin_reset,
  input  wire logic                watchdog_reset_source,
  input  wire logic                mismatch_req,
  input  wire logic                unlocked,
  // Power state events
  input  wire logic                wake_idle,
  input  wire logic                wake_sleep,
  // Register port
  input  wire logic [`ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  // Outputs
  output logic                     system_reset_out,
  output logic                     fetch_enable,
  output logic                     regulator_standby_enable
);

  // ************************************************************
  // Synchronisers and request combine
  // ************************************************************
  logic [2:0] async_sync;
  logic       brownout_s;
  logic       pin_s;
  logic       wdt_s;
  logic       soft_fire;
  logic       any_src;
  logic       fetch_en_w;

  // [RULE15] Two-flop sync of async requests
  sync_2ff #(.WIDTH(3)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({watchdog_reset_source, external_pin_reset, brownout_req}),
    .sync_out (async_sync)
  );

  assign brownout_s = async_sync[0];
  assign pin_s      = async_sync[1];
  assign wdt_s      = async_sync[2];

  // [RULE1] Any source asserts reset
  assign any_src = por_pulse | brownout_s | pin_s | wdt_s | soft_fire | mismatch_req;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      system_reset_out <= 1'b1;
    end else begin
      system_reset_out <= any_src;
    end
  end

  // [RULE14] Eight-clock fetch hold-off
  fetch_delay u_fetch (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sys_rst  (system_reset_out),
    .fetch_en (fetch_en_w)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fetch_enable <= 1'b0;
    end else begin
      fetch_enable <= fetch_en_w & ~system_reset_out;
    end
  end

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic logic hits_reg(input logic [`ADDR_W-1:0] addr,
                                    input logic [`ADDR_W-1:0] base);
    hits_reg = (addr[`ADDR_W-1:4] == base[`ADDR_W-1:4]) && (addr[1:0] == 2'h0);
  endfunction

  // [RULE7] [RULE8] [RULE9] Alias selects by offset
  function automatic alias_op_e alias_of(input logic [`ADDR_W-1:0] addr);
    alias_of = alias_op_e'(addr[3:2]);
  endfunction

  // Read-modify function shared by both registers
  function automatic logic [`CAUSE_W-1:0] apply_write(
      input logic [`CAUSE_W-1:0] cur,
      input logic [`CAUSE_W-1:0] wd,
      input alias_op_e           op);
    unique case (op)
      ALIAS_NONE_OP: apply_write = wd;
      ALIAS_CLR_OP:  apply_write = cur & ~wd;
      ALIAS_SET_OP:  apply_write = cur | wd;
      ALIAS_INV_OP:  apply_write = cur ^ wd;
    endcase
  endfunction

  logic wr_cause;
  logic wr_trig;
  logic rd_trig_base;

  assign wr_cause     = reg_wr && hits_reg(reg_addr, `OFF_CAUSE);
  assign wr_trig      = reg_wr && hits_reg(reg_addr, `OFF_SWTRIG) && unlocked;
  assign rd_trig_base = reg_rd && hits_reg(reg_addr, `OFF_SWTRIG)
                        && (alias_of(reg_addr) == ALIAS_NONE_OP);

  // ************************************************************
  // Cause status register
  // ************************************************************
  logic [`CAUSE_W-1:0] cause_q;
  logic [`CAUSE_W-1:0] cause_d;
  logic [`CAUSE_W-1:0] hw_set;
  logic [`CAUSE_W-1:0] sw_val;

  // [RULE2] Cause event per source
  always_comb begin
    hw_set                = '0;
    hw_set[`BIT_BOR]      = brownout_s;
    hw_set[`BIT_IDLE]     = wake_idle;
    hw_set[`BIT_SLEEP]    = wake_sleep;
    hw_set[`BIT_WDT]      = wdt_s;
    hw_set[`BIT_SOFT]     = soft_fire;
    hw_set[`BIT_PIN]      = pin_s;
    hw_set[`BIT_MISMATCH] = mismatch_req;
  end

  always_comb begin
    sw_val  = cause_q;
    if (wr_cause) begin
      // [RULE4] Software set and clear
      sw_val = apply_write(cause_q, reg_wdata[`CAUSE_W-1:0], alias_of(reg_addr));
    end
    // [RULE16] Hardware set wins
    cause_d = (sw_val | hw_set) & `CAUSE_IMPL_MASK;
    // [RULE3] Power-on reload overrides all
    if (por_pulse) begin
      cause_d = `CAUSE_POR_VALUE;
    end
  end

  // [RULE5] Flags stored, VREG bit also drives regulator_standby_enable; never feed any_src
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cause_q <= `CAUSE_POR_VALUE;
    end else if (por_pulse) begin
      // [RULE3] Power-on status value
      cause_q <= `CAUSE_POR_VALUE;
    end else begin
      cause_q <= cause_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regulator_standby_enable <= 1'b0;
    end else begin
      regulator_standby_enable <= cause_d[`BIT_VREG];
    end
  end

  // ************************************************************
  // Software reset trigger
  // ************************************************************
  logic                trig_q;
  trig_state_e         trig_state_q;
  logic [`CAUSE_W-1:0] trig_next;

  // [RULE6] Single trigger bit
  assign trig_next = apply_write({{(`CAUSE_W-1){1'b0}}, trig_q}, reg_wdata[`CAUSE_W-1:0], alias_of(reg_addr));

  always_ff @(posedge core_clk) begin
    if (!rst_n || soft_fire) begin
      trig_q <= 1'b0;
    end else if (wr_trig) begin
      trig_q <= trig_next[`BIT_TRIG];
    end
  end

  // [RULE13] Read after write fires reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trig_state_q <= TRIG_IDLE;
    end else begin
      unique case (trig_state_q)
        TRIG_IDLE: begin
          // Read straight after the write must fire too
          if (trig_q && rd_trig_base) begin
            trig_state_q <= TRIG_FIRE;
          end else if (trig_q) begin
            trig_state_q <= TRIG_ARMED;
          end
        end
        TRIG_ARMED: begin
          if (!trig_q) begin
            trig_state_q <= TRIG_IDLE;
          end else if (rd_trig_base) begin
            trig_state_q <= TRIG_FIRE;
          end
        end
        TRIG_FIRE:  trig_state_q <= TRIG_IDLE;
        default:    trig_state_q <= TRIG_IDLE;
      endcase
    end
  end

  assign soft_fire = (trig_state_q == TRIG_FIRE);

  // ************************************************************
  // Read data
  // ************************************************************
  // [RULE10] Alias reads return base value; meaningless to software
  // [RULE11] Unimplemented bits read zero
  // [RULE12] Field layout by bit position
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd && hits_reg(reg_addr, `OFF_CAUSE)) begin
      reg_rdata <= {22'h0, cause_q};
    end else if (reg_rd && hits_reg(reg_addr, `OFF_SWTRIG)) begin
      reg_rdata <= {31'h0, trig_q};
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule
`default_nettype wire

/* tb/rsc_assertions.sv */
/* Port assertions for the reset source combiner.
   Assumes binding onto reset_source_combiner, one clock domain. */
`timescale 1ns/100ps
`default_nettype none
`include "rst_comb_consts.svh"
module rsc_chk
  import rst_comb_pkg::*;
(
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               rst_n,
  // Sources
  input wire logic               por_pulse,
  input wire logic               brownout_req,
  input wire logic               external_pin_reset,
  input wire logic               watchdog_reset_source,
  input wire logic               mismatch_req,
  input wire logic               unlocked,
  input wire logic               wake_idle,
  input wire logic               wake_sleep,
  // Register port
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  // Outputs
  input wire logic               system_reset_out,
  input wire logic               fetch_enable,
  input wire logic               regulator_standby_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ********
  // Checks
  // ********
  AST_SYNC_SRC: assert property (mismatch_req |=> system_reset_out)
    else $error("mismatch request gave no reset");
  AST_POR_RST: assert property (por_pulse |=> system_reset_out)
    else $error("power-on pulse gave no reset");
  AST_ASYNC_SRC: assert property ($rose(watchdog_reset_source) |-> ##[2:4] system_reset_out)
    else $error("async request not seen in time");
  AST_FETCH_OFF: assert property (system_reset_out |=> !fetch_enable)
    else $error("fetch allowed during reset");
  AST_FETCH_WAIT: assert property ($fell(system_reset_out) |-> !fetch_enable [*8])
    else $error("fetch allowed too early");
  AST_FETCH_ON: assert property ($fell(system_reset_out) |-> ##[1:14] (fetch_enable || system_reset_out))
    else $error("fetch never allowed");
  AST_HI_ZERO: assert property ($past(reg_rd) |-> reg_rdata[31:10] == 22'h0)
    else $error("unimplemented bits read nonzero");
  // Any status write with every source quiet must leave reset low
  AST_SW_SET: assert property ((reg_wr && reg_addr < 8'h10 && !system_reset_out && !mismatch_req
    && !por_pulse && !brownout_req && !external_pin_reset && !watchdog_reset_source) |=> !system_reset_out)
    else $error("status write caused reset");
  AST_SOFT: assert property ((reg_wr && reg_addr == 8'h18 && reg_wdata[0] && unlocked) ##2
    (reg_rd && reg_addr == 8'h10) |-> ##2 system_reset_out)
    else $error("soft reset did not fire");
  AST_VREG: assert property ((reg_wr && reg_addr == 8'h08 && reg_wdata[8]) |-> ##[1:2] regulator_standby_enable)
    else $error("standby enable not set");
  cover property ($fell(system_reset_out));
  cover property ($rose(fetch_enable));
  cover property (reg_rd && reg_addr == 8'h10 ##2 system_reset_out);
endmodule
bind reset_source_combiner rsc_chk rsc_chk_inst (.*);
`default_nettype wire

/* tb/src_detectors.sv */
/* Detector model: brown-out, pin and watchdog request levels.
   Assumes the bench holds each request for many clocks. */
`timescale 1ns/100ps
`default_nettype none
module src_detectors (
  // Request from bench
  input  wire logic [2:0] req,
  // Async levels
  output logic            brownout_req,
  output logic            external_pin_reset,
  output logic            watchdog_reset_source
);
  // ********
  // Levels
  // ********
  // Off-edge change, since real detectors ignore the clock
  initial begin
    {brownout_req, external_pin_reset, watchdog_reset_source} = 3'h0;
    forever begin
      @(req);
      #1.3 {brownout_req, external_pin_reset, watchdog_reset_source} <= req;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/* Self-checking bench of the reset source combiner.
   Assumes rtl/ on the include path and the detector model. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        core_clk = 1'b0, rst_n = 1'b0, por_pulse = 1'b0;
  logic        mismatch_req = 1'b0, unlocked = 1'b0, wake_idle = 1'b0;
  logic        wake_sleep = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  logic [2:0]  req = 3'h0;
  logic [15:0] lfsr_q = 16'h74cf;
  logic        brownout_req, external_pin_reset, watchdog_reset_source;
  logic        system_reset_out, fetch_enable, regulator_standby_enable;
  int          num_errors = 0, cmp_count = 0, m = 3, tr = 0, k;
  int          bits[4] = '{4, 7, 1, 9};

  initial forever #2.5 core_clk = ~core_clk;

  reset_source_combiner reset_source_combiner_inst (.core_clk, .rst_n, .por_pulse, .brownout_req,
    .external_pin_reset, .watchdog_reset_source, .mismatch_req, .unlocked, .wake_idle, .wake_sleep,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .system_reset_out, .fetch_enable,
    .regulator_standby_enable);
  src_detectors src_detectors_inst (.req, .brownout_req, .external_pin_reset, .watchdog_reset_source);

  // ********
  // Helpers
  // ********
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction
  function automatic int op(int c, int d, logic [1:0] kd);
    case (kd)
      2'h0: return d;
      2'h1: return c & ~d;
      2'h2: return c | d;
      default: return c ^ d;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Strobe drops one edge later, so calls never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    wake_idle <= 1'b0;
    wake_sleep <= 1'b0;
    if (a < 8'h10) m = op(m, d, a[3:2]) & 32'h3df;
    else if (a < 8'h20 && unlocked) tr = op(tr, d, a[3:2]) & 1;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic wait_fetch();
    for (int i = 0; i < 40 && fetch_enable !== 1'b1; i++) @(negedge core_clk);
    chk(fetch_enable, 1, "fetch");
    @(posedge core_clk);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #40000;
    num_errors++;
    tally_and_finish();
  end

  // ********
  // Scenarios
  // ********
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_fetch();
    rd(8'h00, v);
    chk(v, m, "status reset");
    wr(8'h20, 32'hffffffff);
    rd(8'h20, v);
    chk(v, 0, "unmapped");
    for (k = 0; k < 40; k++) begin
      v = {rnd(), rnd()};
      wr({4'h0, v[31:30], 2'h0}, v);
      rd(8'h00, v);
      chk(v, m, "status");
      chk(regulator_standby_enable, (m >> 8) & 1, "standby");
      chk(system_reset_out, 0, "no soft reset");
    end
    wake_idle <= 1'b1;
    wake_sleep <= 1'b1;
    wr(8'h04, 32'hc);
    m = m | 32'hc;
    rd(8'h00, v);
    chk(v, m, "set beats clear");
    for (k = 0; k < 4; k++) begin
      if (k < 3) req[k] <= 1'b1;
      else mismatch_req <= 1'b1;
      repeat (6) @(negedge core_clk);
      chk(system_reset_out, 1, "source reset");
      @(posedge core_clk);
      req <= 3'h0;
      mismatch_req <= 1'b0;
      m = m | (1 << bits[k]);
      wait_fetch();
      rd(8'h00, v);
      chk(v, m, "cause flag");
    end
    wr(8'h18, 32'h1);
    rd(8'h10, v);
    chk(v, 0, "locked trigger");
    unlocked <= 1'b1;
    @(posedge core_clk);
    wr(8'h18, 32'h1);
    rd(8'h10, v);
    chk(v, tr, "trigger bit");
    m = m | 32'h40;
    tr = 0;
    @(negedge core_clk);
    chk(system_reset_out, 1, "soft reset");
    wait_fetch();
    rd(8'h00, v);
    chk(v, m, "soft flag");
    // Standby bit set so the power-on reload must visibly clear it
    wr(8'h08, 32'h100);
    por_pulse <= 1'b1;
    @(posedge core_clk);
    por_pulse <= 1'b0;
    m = 3;
    @(negedge core_clk);
    chk(system_reset_out, 1, "por reset");
    chk(regulator_standby_enable, 0, "por standby");
    wait_fetch();
    rd(8'h00, v);
    chk(v, m, "por status");
    tally_and_finish();
  end
endmodule
`default_nettype wire
